// file: design/mrc_defines.svh
`ifndef MRC_DEFINES_SVH
`define MRC_DEFINES_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MRC_CLK_PERIOD_NS   100
`define MRC_STANDBY_MAX_US  8
`define MRC_STANDBY_CYC     ((`MRC_STANDBY_MAX_US * 1000) / `MRC_CLK_PERIOD_NS)
`define MRC_CS_HIGH_MIN_US  5
`define MRC_SDO_DIS_MAX_NS  75
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MRC_CTRL_RESET      16'h0000
`define MRC_NRF_RESET       1'b0
`endif

// file: design/mrc_pkg.sv
package mrc_pkg;
   typedef enum logic [2:0] {
      MRC_ST_OFF    = 3'b001,
      MRC_ST_SLEEP  = 3'b010,
      MRC_ST_NORMAL = 3'b100
   } mrc_state_t;

   typedef struct packed {
      logic        supply_ok;
      logic        bridge_ok;
      logic        mode_high;
   } mrc_sense_t;
endpackage

// file: design/mrc_mode_reset_ctrl.sv
`timescale 1ns/100ps
`include "mrc_defines.svh"
// Function
// - Rising logic supply past power-on threshold applies an internal reset of all logic.
// - Power-on reset clears every held setting and puts all bridge outputs in high impedance.
// - Settings survive bridge supply drop-outs so operation resumes without new commands.
// - Mode pin high selects normal mode where outputs are configurable over the serial port.
// - Mode pin low enters sleep, turns outputs off and returns settings to reset values.
// - Entry into standby completes within 8 us of the mode pin falling edge.
// - Logic supply below power-off threshold stops the serial port, clears logic, outputs off.
// - After logic supply returns, logic is initialized and the not-reset flag reads 0.
// - A mode pin reset is reported by the not-reset flag reading 0 back in normal mode.
// - Serial out is driven after chip select falls and released within 75 ns of it rising.
// - Bridge supply faults force outputs off, keep settings, and recover automatically.
module mrc_mode_reset_ctrl #(
   parameter int CTRL_W = 16
) (
   // Clocks and reset
   input  wire logic              clock_in,
   input  wire logic              reset_in,
   input  wire logic              link_clock_in,
   // Supply and mode sense (asynchronous pins)
   input  wire logic              supply_ok_in,
   input  wire logic              bridge_ok_in,
   input  wire logic              mode_pin_in,
   // Serial frame side (link domain)
   input  wire logic              chip_select_low_in,
   input  wire logic              serial_bit_in,
   // Control settings written by serial logic
   input  wire logic              ctrl_we_in,
   input  wire logic [CTRL_W-1:0] ctrl_wdata_in,
   input  wire logic              nrf_set_in,
   // Outputs
   output logic [CTRL_W-1:0]      ctrl_out,
   output logic                   stage_enable_out,
   output logic                   serial_enable_out,
   output logic                   not_reset_flag_out,
   output logic                   logic_reset_out,
   output logic                   serial_out_pin_out,
   output logic                   serial_out_pin_oe_n_out
);
   // Settings reset constant is 16 bits wide
   if (CTRL_W < 1 || CTRL_W > 16) begin : g_width_check
      $error("CTRL_W out of range");
   end

   function automatic logic is_normal(input mrc_pkg::mrc_state_t st);
      return st == mrc_pkg::MRC_ST_NORMAL;
   endfunction

   // Longest stay in normal mode with the mode pin low
   localparam logic [7:0] STBY_CYC = 8'(`MRC_STANDBY_CYC);

   // ----------------------------------------------------------------
   // Core domain state
   // ----------------------------------------------------------------
   typedef struct packed {
      mrc_pkg::mrc_sense_t  s1;
      mrc_pkg::mrc_sense_t  s2;
      mrc_pkg::mrc_state_t  st;
      logic [CTRL_W-1:0]    ctrl;
      logic                 nrf;
      logic                 stage_en;
      logic                 ser_en;
      logic                 lrst;
      logic [7:0]           cnt;
   } mrc_core_t;

   mrc_core_t c_q, c_d;

   always_comb begin
      c_d = c_q;
      // Two-flop synchronisers; only s2 is read by the logic
      c_d.s1 = '{supply_ok: supply_ok_in, bridge_ok: bridge_ok_in, mode_high: mode_pin_in};
      c_d.s2 = c_q.s1;
      // Logic reset is raised only outside normal mode
      c_d.lrst = 1'b0;
      case (c_q.st)
         mrc_pkg::MRC_ST_OFF: begin
            c_d.ctrl = CTRL_W'(`MRC_CTRL_RESET);
            c_d.nrf  = `MRC_NRF_RESET;
            c_d.lrst = 1'b1;
            if (c_q.s2.supply_ok) begin
               c_d.st = mrc_pkg::MRC_ST_SLEEP;
            end
         end
         mrc_pkg::MRC_ST_SLEEP: begin
            c_d.ctrl = CTRL_W'(`MRC_CTRL_RESET);
            c_d.lrst = 1'b1;
            if (c_q.s2.mode_high) begin
               c_d.st = mrc_pkg::MRC_ST_NORMAL;
            end
         end
         mrc_pkg::MRC_ST_NORMAL: begin
            if (ctrl_we_in) begin
               c_d.ctrl = ctrl_wdata_in;
            end
            if (nrf_set_in) begin
               c_d.nrf = 1'b1;
            end
            // Mode reset wins over a set request in the same cycle
            if (!c_q.s2.mode_high) begin
               c_d.st  = mrc_pkg::MRC_ST_SLEEP;
               c_d.nrf = 1'b0;
            end
         end
         default: c_d.st = mrc_pkg::MRC_ST_OFF;
      endcase
      // Supply loss overrides every state
      if (!c_q.s2.supply_ok) begin
         c_d.st = mrc_pkg::MRC_ST_OFF;
      end
      // Bridge faults gate the stages only; settings are untouched
      // Stages come on one cycle into normal mode, never straight from sleep
      c_d.stage_en = is_normal(c_q.st) && is_normal(c_d.st) && c_q.s2.bridge_ok;
      c_d.ser_en   = is_normal(c_d.st);
      c_d.cnt = (c_q.s2.mode_high || c_q.cnt == 8'hff) ? 8'h00 : 8'(c_q.cnt + 8'h01);
   end

   // Synchronous reset holds the block as at power-on
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         c_q <= '{s1: '0, s2: '0, st: mrc_pkg::MRC_ST_OFF, ctrl: '0, nrf: 1'b0,
                  stage_en: 1'b0, ser_en: 1'b0, lrst: 1'b1, cnt: 8'h00};
      end else begin
         c_q <= c_d;
      end
   end

   assign ctrl_out           = c_q.ctrl;
   assign stage_enable_out   = c_q.stage_en;
   assign serial_enable_out  = c_q.ser_en;
   assign not_reset_flag_out = c_q.nrf;
   assign logic_reset_out    = c_q.lrst;

   // ----------------------------------------------------------------
   // Link domain: serial output driver
   // ----------------------------------------------------------------
   // Serial enable crosses through en1 and en2
   typedef struct packed {
      logic en1;
      logic en2;
      logic dout;
   } mrc_link_t;

   mrc_link_t l_q, l_d;
   logic      oe_n_q;
   logic      oe_n_d;

   always_comb begin
      l_d      = l_q;
      l_d.en1  = c_q.ser_en;
      l_d.en2  = l_q.en1;
      l_d.dout = serial_bit_in;
      oe_n_d   = !(l_q.en2 && !chip_select_low_in);
   end

   // Release is asynchronous to the link clock so it meets 75 ns
   // Own register, so the asynchronous release touches nothing else
   always_ff @(posedge link_clock_in or posedge chip_select_low_in) begin
      if (chip_select_low_in) begin
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= oe_n_d;
      end
   end

   always_ff @(posedge link_clock_in) begin
      l_q <= l_d;
   end

   assign serial_out_pin_out      = l_q.dout;
   assign serial_out_pin_oe_n_out = oe_n_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   standby_time_a: assert property (@(posedge clock_in) disable iff (reset_in)
      $fell(c_q.s2.mode_high) |-> ##[0:2] (c_q.st != mrc_pkg::MRC_ST_NORMAL))
      else $error("standby not reached in time");
   standby_bound_a: assert property (@(posedge clock_in) disable iff (reset_in)
      c_q.cnt < STBY_CYC || c_q.st != mrc_pkg::MRC_ST_NORMAL)
      else $error("standby later than 8 us");
   supply_off_a: assert property (@(posedge clock_in) disable iff (reset_in)
      !c_q.s2.supply_ok |=> (!c_q.stage_en && !c_q.ser_en))
      else $error("outputs active without logic supply");
   por_clear_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (c_q.st == mrc_pkg::MRC_ST_OFF) |=> (c_q.ctrl == '0 && !c_q.stage_en))
      else $error("settings not cleared at power-on");
   flag_zero_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (c_q.st == mrc_pkg::MRC_ST_OFF) |=> !c_q.nrf)
      else $error("not-reset flag set after power-on");
   sleep_reset_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (c_q.st == mrc_pkg::MRC_ST_SLEEP) |=> (c_q.ctrl == '0 && !c_q.stage_en))
      else $error("sleep did not reset settings");
   mode_flag_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (c_q.st == mrc_pkg::MRC_ST_NORMAL && !c_q.s2.mode_high) |=> !c_q.nrf)
      else $error("mode reset not reported");
   bridge_hold_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (c_q.st == mrc_pkg::MRC_ST_NORMAL && !c_q.s2.bridge_ok && c_q.s2.mode_high
       && c_q.s2.supply_ok && !ctrl_we_in) |=> (!c_q.stage_en && $stable(c_q.ctrl)))
      else $error("bridge fault disturbed settings");
   normal_mode_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (c_q.st == mrc_pkg::MRC_ST_NORMAL && ctrl_we_in && c_q.s2.mode_high
       && c_q.s2.supply_ok) |=> (c_q.ctrl == $past(ctrl_wdata_in)))
      else $error("normal mode write lost");
   power_up_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (c_q.st == mrc_pkg::MRC_ST_OFF && c_q.s2.supply_ok)
      |=> (c_q.st == mrc_pkg::MRC_ST_SLEEP && c_q.lrst))
      else $error("no internal reset on supply rise");
   supply_reset_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (c_q.st == mrc_pkg::MRC_ST_OFF)
      |=> (c_q.lrst && !c_q.ser_en && !c_q.stage_en))
      else $error("logic active without logic supply");
   bridge_resume_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (c_q.st == mrc_pkg::MRC_ST_NORMAL && c_q.s2.bridge_ok && c_q.s2.mode_high
       && c_q.s2.supply_ok) |=> c_q.stage_en)
      else $error("stages not back after bridge recovery");
   sdo_release_a: assert property (@(posedge link_clock_in)
      chip_select_low_in |-> oe_n_q)
      else $error("serial out driven with chip select high");
endmodule

// file: verification/mrc_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host model: mode pin and serial frames
// ----------------------------------------
module mrc_host_model (
   // Link side
   output logic link_clock_out,
   output logic chip_select_low_out,
   output logic serial_bit_out,
   // Mode pin
   output logic mode_pin_out
);
   realtime t_up = -1.0e6;
   initial begin
      link_clock_out      = 1'b0;
      chip_select_low_out = 1'b1;
      serial_bit_out      = 1'b0;
      mode_pin_out        = 1'b0;
   end
   task automatic set_mode(input logic m);
      mode_pin_out = m;
   endtask
   // Link clock runs only inside a frame
   task automatic start(input logic b);
      if ($realtime - t_up < 5000.0)
         #(5000.0 - ($realtime - t_up));
      chip_select_low_out = 1'b0;
      serial_bit_out      = b;
      repeat (4) begin
         #32 link_clock_out = 1'b1;
         #32 link_clock_out = 1'b0;
      end
   endtask
   task automatic stop();
      chip_select_low_out = 1'b1;
      serial_bit_out      = ~serial_bit_out;
      t_up                = $realtime;
   endtask
endmodule

// file: verification/tb_mode_and_reset_control.sv
`timescale 1ns/100ps
`include "mrc_defines.svh"
module tb_mode_and_reset_control;
   logic        clock_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        sup_ok   = 1'b0;
   logic        brg_ok   = 1'b1;
   logic        we       = 1'b0;
   logic        nrf_set  = 1'b0;
   logic [15:0] wdata    = 16'h0000;
   logic        lclk, csl, sbit, mode, b;
   logic [15:0] ctrl;
   logic        stage, sen, nrf, lrst, sout, oe_n;
   int          miscompares = 0;
   int          check_count = 0;
   int          exp_nrf     = 0;
   int          mdl_on      = 0;
   int          hist[$];
   int          i;
   always #50 clock_in = ~clock_in;
   mrc_host_model host (.link_clock_out(lclk), .chip_select_low_out(csl),
      .serial_bit_out(sbit), .mode_pin_out(mode));
   mrc_mode_reset_ctrl uut (.clock_in(clock_in), .reset_in(reset_in), .link_clock_in(lclk),
      .supply_ok_in(sup_ok), .bridge_ok_in(brg_ok), .mode_pin_in(mode),
      .chip_select_low_in(csl), .serial_bit_in(sbit), .ctrl_we_in(we),
      .ctrl_wdata_in(wdata), .nrf_set_in(nrf_set), .ctrl_out(ctrl),
      .stage_enable_out(stage), .serial_enable_out(sen), .not_reset_flag_out(nrf),
      .logic_reset_out(lrst), .serial_out_pin_out(sout), .serial_out_pin_oe_n_out(oe_n));
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic bound();
      if (i >= 100) begin
         miscompares++;
         summarize();
      end
   endtask
   // Model: settings accepted in normal mode, last one is live
   function automatic int exp_ctrl();
      return (hist.size() == 0) ? 0 : hist[$];
   endfunction
   task automatic mdl_reset();
      hist.delete();
      exp_nrf = 0;
      mdl_on  = 0;
   endtask
   task automatic wait_sen();
      for (i = 0; i < 100 && sen !== 1'b1; i++)
         tick(1);
      bound();
      // One more edge drops the logic reset and turns the stages on
      tick(1);
   endtask
   task automatic write(input logic [15:0] d, input logic s);
      wdata   = d;
      we      = 1'b1;
      nrf_set = s;
      tick(1);
      we      = 1'b0;
      nrf_set = 1'b0;
      if (mdl_on != 0) begin
         hist.push_back(int'(d));
         exp_nrf = exp_nrf | int'(s);
      end
      tick(3);
   endtask
   initial begin
      void'($urandom(32'h2380));
      tick(12);
      reset_in = 1'b0;
      tick(1);
      check(ctrl, 16'(exp_ctrl()));
      check(16'({stage, sen, nrf, lrst}), 16'h0001);
      sup_ok = 1'b1;
      host.set_mode(1'b1);
      wait_sen();
      mdl_on = 1;
      check(16'({stage, nrf, lrst}), 16'h0004);
      write(16'($urandom), 1'b1);
      check(ctrl, 16'(exp_ctrl()));
      check(16'(nrf), 16'(exp_nrf));
      $display("Test normal mode done");
      brg_ok = 1'b0;
      tick(5);
      check(16'(stage), 16'h0000);
      check(ctrl, 16'(exp_ctrl()));
      brg_ok = 1'b1;
      tick(5);
      check(16'(stage), 16'h0001);
      check(ctrl, 16'(exp_ctrl()));
      $display("Test bridge fault done");
      b = 1'($urandom);
      #13;
      host.start(b);
      check(16'({oe_n, sout}), 16'(b));
      host.stop();
      #75;
      check(16'(oe_n), 16'h0001);
      tick(1);
      $display("Test frame done");
      host.set_mode(1'b0);
      mdl_reset();
      for (i = 0; i < 100 && stage !== 1'b0; i++)
         tick(1);
      bound();
      check(16'(i <= `MRC_STANDBY_CYC), 16'h0001);
      tick(2);
      check(16'({sen, nrf, lrst}), 16'h0001);
      write(16'hffff, 1'b1);
      check(ctrl, 16'(exp_ctrl()));
      host.set_mode(1'b1);
      wait_sen();
      mdl_on = 1;
      check(16'(nrf), 16'(exp_nrf));
      $display("Test sleep done");
      write(16'h5a5a, 1'b1);
      check(ctrl, 16'(exp_ctrl()));
      sup_ok = 1'b0;
      mdl_reset();
      tick(5);
      check(ctrl, 16'(exp_ctrl()));
      check(16'({stage, sen, lrst}), 16'h0001);
      sup_ok = 1'b1;
      wait_sen();
      mdl_on = 1;
      check(ctrl, 16'(exp_ctrl()));
      check(16'(nrf), 16'(exp_nrf));
      $display("Test supply drop done");
      summarize();
   end
endmodule
